// *** iac_ctrl.sv ***
// configuration, addressing and command checks of the two-wire controller
// assumes an APB-style register port on ref_clk_i and a bus engine that
// reports addresses and stops on its own link clock
//
// Functional notes
// - bit 10 reads zero; stops reported unless bit 7 drops an unmatched slave stop
// - bit 9 holds bus on full receive
// - bit 8 selects transmit-empty generation
// - slave stop reported only when matched, optionally
// - bit 6 disables slave, resets one
// - without restart, forbidden operations abort
// - without restart, stop then start substitutes
// - bit 4 selects master 10-bit addressing
// - bit 3 selects slave 7/10-bit compare
// - speed field encodes three speeds
// - illegal speed stores built-in top rate
// - speed also selects spike filter length
// - bit 0 enables master, resets one
// - target register twelve bits, locked when enabled
// - target bit 11 selects special commands
// - general call mode rejects read commands
// - target address resets 0x055, ignored on call
// - no self transmit, one-direction loopback
// - own address resets 0x055, locked when enabled
// - one read command per received byte
// - control register locked while enabled
`timescale 1ns/1ns
module iac_ctrl
   import iac_pkg::*;
#(
   parameter logic [1:0] TOP_RATE  = 2'h3,  // built_in_top_rate
   parameter logic [7:0] SPK_SS_FS = 8'h07, // spike length, std/fast
   parameter logic [7:0] SPK_HS    = 8'h01, // spike length, high speed
   parameter int         CREDIT_W  = 8
) (
   input  wire logic              ref_clk_i,       // system clock
   input  wire logic              sys_rst_i,       // sync reset, high
   input  wire logic              psel_i,          // register select
   input  wire logic              penable_i,       // access phase
   input  wire logic              pwrite_i,        // write access
   input  wire logic [ADDR_W-1:0] paddr_i,         // byte address
   input  wire logic [31:0]       pwdata_i,        // write data
   output logic [31:0]            prdata_o,        // read data
   output logic                   pready_o,        // access done
   output logic                   pslverr_o,       // unmapped address
   output iac_cmd_t               cmd_o,           // command to engine
   output logic                   cmd_vld_o,       // command valid
   input  wire logic              cmd_rdy_i,       // engine took command
   input  wire logic [7:0]        rx_data_i,       // received byte
   input  wire logic              rx_first_i,      // first byte flag
   input  wire logic              rx_full_i,       // receive store full
   input  wire logic              rx_byte_i,       // byte received pulse
   output logic                   rx_pop_o,        // data read pulse
   output logic                   ack_more_o,      // read credit left
   output logic                   hold_bus_o,      // stall on full
   output logic                   tx_empty_ctrl_o, // tx-empty mode
   output logic                   master_en_o,     // master active
   output logic                   slave_en_o,      // slave active
   output logic [1:0]             speed_o,         // speed mode
   output logic [7:0]             spike_len_o,     // spike filter
   output logic                   loopback_o,      // target is self
   input  wire logic              link_clk_i,      // bus engine clock
   input  wire logic              link_addr_vld_i, // address received
   input  wire iac_saddr_t        link_addr_i,     // received address
   input  wire logic              link_stop_i,     // stop seen pulse
   output logic                   slave_match_o    // own address hit
);
   import iac_pkg::*;

   // -----------------------------------------------------------------
   // register port
   // -----------------------------------------------------------------
   iac_ctrl_t             ctrl;
   iac_tar_t              tar;
   logic [9:0]            sar;
   logic                  en;
   logic                  raw_abrt;
   logic                  raw_stop;
   logic                  last_rd;
   logic [CREDIT_W-1:0]   credit;
   logic                  acc;
   logic                  wr;
   logic                  rd;
   logic                  mapped;
   logic                  stall;
   logic                  dcmd_wr;
   logic                  abort;
   logic                  stop_evt;
   iac_cmd_t              next_cmd;

   function automatic logic [1:0] clamp_speed(input logic [1:0] s);
      if (s == 2'h0 || s > TOP_RATE) begin
         return TOP_RATE;
      end
      return s;
   endfunction

   assign mapped = (paddr_i == OFS_CTRL) || (paddr_i == OFS_TAR) ||
                   (paddr_i == OFS_SAR) || (paddr_i == OFS_DCMD) ||
                   (paddr_i == OFS_RAW) || (paddr_i == OFS_CLR_ABRT) ||
                   (paddr_i == OFS_CLR_STOP) || (paddr_i == OFS_EN);
   // a command write waits while the previous one is still offered
   assign stall     = pwrite_i && (paddr_i == OFS_DCMD) && cmd_vld_o;
   assign pready_o  = !stall;
   assign pslverr_o = psel_i && penable_i && !mapped;
   assign acc       = psel_i && penable_i && pready_o && mapped;
   assign wr        = acc && pwrite_i;
   assign rd        = acc && !pwrite_i;
   assign dcmd_wr   = wr && (paddr_i == OFS_DCMD) && en;
   assign rx_pop_o  = rd && (paddr_i == OFS_DCMD);

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         ctrl <= iac_ctrl_t'(CTRL_RST);
      end else if (wr && paddr_i == OFS_CTRL && !en) begin
         ctrl                        <= iac_ctrl_t'(pwdata_i[10:0]);
         ctrl.stop_irq_master_always <= 1'b0;
         ctrl.speed                  <= clamp_speed(pwdata_i[2:1]);
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         tar <= iac_tar_t'(TAR_RST);
         sar <= SAR_RST;
      end else if (wr && !en) begin
         if (paddr_i == OFS_TAR) begin
            tar <= iac_tar_t'(pwdata_i[11:0]);
         end
         if (paddr_i == OFS_SAR) begin
            sar <= pwdata_i[9:0];
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         en <= 1'b0;
      end else if (wr && paddr_i == OFS_EN) begin
         en <= pwdata_i[0];
      end
   end

   // read data is captured in the setup phase so it comes from a flop
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         prdata_o <= 32'h0000_0000;
      end else if (psel_i && !penable_i && !pwrite_i) begin
         prdata_o <= 32'h0000_0000;
         case (paddr_i)
            OFS_CTRL: prdata_o[10:0] <= {1'b0, ctrl[9:0]};
            OFS_TAR:  prdata_o[11:0] <= tar;
            OFS_SAR:  prdata_o[9:0]  <= sar;
            OFS_DCMD: prdata_o[11:0] <= {rx_first_i, 3'h0, rx_data_i};
            OFS_RAW: begin
               prdata_o[RAW_ABRT_BIT] <= raw_abrt;
               prdata_o[RAW_STOP_BIT] <= raw_stop;
            end
            OFS_CLR_ABRT: prdata_o[0] <= raw_abrt;
            OFS_CLR_STOP: prdata_o[0] <= raw_stop;
            OFS_EN:   prdata_o[0]    <= en;
            default:  prdata_o       <= 32'h0000_0000;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // command checks
   // -----------------------------------------------------------------
   always_comb begin
      next_cmd              = '0;
      next_cmd.read         = pwdata_i[DCMD_READ_BIT];
      next_cmd.stop         = pwdata_i[DCMD_STOP_BIT];
      next_cmd.data         = pwdata_i[7:0];
      next_cmd.wide         = ctrl.master_wide_addressing;
      next_cmd.general_call = tar.special && !tar.general_call_or_start_byte;
      next_cmd.start_byte   = tar.special && tar.general_call_or_start_byte;
      next_cmd.addr         = next_cmd.general_call ? 10'h000 : tar.addr;
      if (pwdata_i[DCMD_RSTRT_BIT] || (next_cmd.read != last_rd)) begin
         next_cmd.restart    = ctrl.repeated_start_allow;
         next_cmd.stop_start = !ctrl.repeated_start_allow;
      end
   end

   assign loopback_o = !ctrl.slave_off && (tar.addr == sar);
   assign abort = ctrl.master_on && (
                  (next_cmd.read && next_cmd.general_call) ||
                  (!ctrl.repeated_start_allow && (next_cmd.start_byte ||
                   ctrl.speed == SPD_HIGH ||
                   (next_cmd.read && ctrl.master_wide_addressing))) ||
                  (!next_cmd.read && loopback_o && !tar.special));

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         cmd_vld_o <= 1'b0;
         cmd_o     <= '0;
         last_rd   <= 1'b0;
      end else if (dcmd_wr && !abort) begin
         cmd_vld_o <= 1'b1;
         cmd_o     <= next_cmd;
         last_rd   <= next_cmd.read;
      end else if (cmd_rdy_i) begin
         cmd_vld_o <= 1'b0;
      end
   end

   // credit of queued reads; the engine stops acknowledging at zero
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         credit <= '0;
      end else begin
         case ({cmd_vld_o && cmd_rdy_i && cmd_o.read, rx_byte_i && credit != '0})
            2'b10:   credit <= credit + 1'b1;
            2'b01:   credit <= credit - 1'b1;
            default: credit <= credit;
         endcase
      end
   end
   assign ack_more_o = (credit != '0);

   // -----------------------------------------------------------------
   // raw status; a new event beats a clear in the same cycle
   // -----------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         raw_abrt <= 1'b0;
      end else if (dcmd_wr && abort) begin
         raw_abrt <= 1'b1;
      end else if (rd && paddr_i == OFS_CLR_ABRT) begin
         raw_abrt <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         raw_stop <= 1'b0;
      end else if (stop_evt) begin
         raw_stop <= 1'b1;
      end else if (rd && paddr_i == OFS_CLR_STOP) begin
         raw_stop <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // mode outputs
   // -----------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         hold_bus_o      <= 1'b0;
         tx_empty_ctrl_o <= 1'b0;
         master_en_o     <= 1'b0;
         slave_en_o      <= 1'b0;
         speed_o         <= SPD_FAST;
         spike_len_o     <= SPK_SS_FS;
      end else begin
         hold_bus_o      <= ctrl.hold_bus_on_rx_full && rx_full_i;
         tx_empty_ctrl_o <= ctrl.tx_empty_ctrl;
         master_en_o     <= en && ctrl.master_on;
         slave_en_o      <= en && !ctrl.slave_off;
         speed_o         <= ctrl.speed;
         spike_len_o     <= (ctrl.speed == SPD_HIGH) ? SPK_HS : SPK_SS_FS;
      end
   end

   // -----------------------------------------------------------------
   // link domain
   // -----------------------------------------------------------------
   logic       lrst_meta;
   logic       lrst;
   logic       len_meta;
   logic       len;
   logic [9:0] lk_sar;
   logic       lk_wide;
   logic       lk_only;
   logic       lk_soff;
   logic       hit;
   logic       stop_tgl;
   logic       stop_s1;
   logic       stop_s2;
   logic       stop_s3;

   always_ff @(posedge link_clk_i) begin
      lrst_meta <= sys_rst_i;
      lrst      <= lrst_meta;
      len_meta  <= en;
      len       <= len_meta;
   end

   // settings are frozen while enabled, so sampling them only while the
   // synchronised enable is low never catches a word in motion
   always_ff @(posedge link_clk_i) begin
      if (lrst) begin
         lk_sar  <= SAR_RST;
         lk_wide <= 1'b0;
         lk_only <= 1'b0;
         lk_soff <= 1'b1;
      end else if (!len) begin
         lk_sar  <= sar;
         lk_wide <= ctrl.slave_wide_addressing;
         lk_only <= ctrl.stop_irq_when_matched;
         lk_soff <= ctrl.slave_off;
      end
   end

   assign hit = link_addr_vld_i && len && !lk_soff && (lk_wide ?
                (link_addr_i.wide && link_addr_i.addr == lk_sar) :
                (!link_addr_i.wide && link_addr_i.addr[6:0] == lk_sar[6:0]));

   always_ff @(posedge link_clk_i) begin
      if (lrst) begin
         slave_match_o <= 1'b0;
         stop_tgl      <= 1'b0;
      end else begin
         if (link_stop_i) begin
            slave_match_o <= 1'b0;
         end else if (hit) begin
            slave_match_o <= 1'b1;
         end
         if (link_stop_i && len &&
             (lk_soff || !lk_only || slave_match_o)) begin
            stop_tgl <= !stop_tgl;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         stop_s1 <= 1'b0;
         stop_s2 <= 1'b0;
         stop_s3 <= 1'b0;
      end else begin
         stop_s1 <= stop_tgl;
         stop_s2 <= stop_s1;
         stop_s3 <= stop_s2;
      end
   end
   assign stop_evt = stop_s2 ^ stop_s3;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   a_ctrl_locked: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (wr && paddr_i == OFS_CTRL && en) |=> $stable(ctrl))
      else $error("control changed while enabled");
   a_tar_locked: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (wr && paddr_i == OFS_TAR && en) |=> $stable(tar))
      else $error("target changed while enabled");
   a_sar_locked: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (wr && paddr_i == OFS_SAR && en) |=> $stable(sar))
      else $error("own address changed while enabled");
   a_speed_clamp: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (wr && paddr_i == OFS_CTRL && !en && pwdata_i[2:1] == 2'h0)
      |=> ctrl.speed == TOP_RATE ##2 speed_o == TOP_RATE)
      else $error("illegal speed not clamped");
   a_bit10_zero: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (rd && paddr_i == OFS_CTRL) |-> prdata_o[10] == 1'b0)
      else $error("control bit 10 not zero");
   a_gc_read_abort: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (dcmd_wr && ctrl.master_on && pwdata_i[DCMD_READ_BIT] && next_cmd.general_call)
      |=> raw_abrt && $stable(cmd_o))
      else $error("read in general call mode not aborted");
   a_no_restart: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      $rose(cmd_vld_o) && !ctrl.repeated_start_allow |-> !cmd_o.restart)
      else $error("restart issued while disallowed");
   a_read_credit: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (cmd_vld_o && cmd_rdy_i && cmd_o.read && !rx_byte_i)
      |=> credit == $past(credit) + 1'b1 ##0 ack_more_o)
      else $error("read credit not counted");
   a_slave_off: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      ctrl.slave_off ##1 ctrl.slave_off |-> !slave_en_o)
      else $error("slave active while disabled");
   a_slave_cmp: assert property (@(posedge link_clk_i) disable iff (lrst)
      (link_addr_vld_i && !lk_wide && link_addr_i.wide) |-> !hit)
      else $error("7-bit slave matched a 10-bit transfer");
   a_stop_report: assert property (@(posedge link_clk_i) disable iff (lrst)
      (link_stop_i && len && !lk_only) |=> stop_tgl != $past(stop_tgl))
      else $error("stop not reported");

endmodule // iac_ctrl

// *** iac_ctrl_tb.sv ***
// self-checking bench of the addressing controller with a register model
// assumes the engine stand-in and the package in the same folder
`timescale 1ns/1ns
module iac_ctrl_tb;
   import iac_pkg::*;
   localparam logic [1:0] TOP    = 2'h3;
   localparam logic [7:0] SPK_SS = 8'h07;
   localparam logic [7:0] SPK_H  = 8'h01;
   logic        clk = 0, lclk = 0, rst = 1;
   logic        psel = 0, pen = 0, pwr = 0, err;
   logic [7:0]  paddr = '0, rx_data = '0, spike;
   logic [31:0] pwdata = '0, prdata, rd, v, st = 32'd56333;
   logic        pready, pslverr, rdy, avld, lstop, cvld, rx_pop, ack_more;
   logic        hold, txe, men, sen, loopb, smatch;
   logic        rx_first = 0, rx_full = 0, rx_byte = 0;
   logic [1:0]  speed;
   iac_cmd_t    cmd, g;
   iac_saddr_t  laddr;
   int          failures = 0, cmp_count = 0, pops = 0;
   logic [31:0] m_ctl = CTRL_RST, m_tar = TAR_RST, m_sar = SAR_RST;
   logic        m_en = 0;
   logic [10:0] ct [7] = '{11'h065, 11'h045, 11'h047, 11'h055, 11'h065, 11'h065, 11'h045};
   logic [11:0] tg [7] = '{12'h055, 12'hC55, 12'h055, 12'h055, 12'h855, 12'h855, 12'h055};
   logic [2:0]  dc [7] = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h0, 3'h4};
   logic [0:6]  ab = 7'b0111100;
   logic [10:0] sc [6] = '{11'h0A4, 11'h0A4, 11'h0A4, 11'h0AC, 11'h0AC, 11'h024};
   logic [9:0]  sa [6] = '{10'h055, 10'h056, 10'h2D5, 10'h2D5, 10'h0D5, 10'h056};
   logic [0:5]  sw = 6'b001110, sp = 6'b100101;

   initial forever #4 clk = ~clk;
   // read pops are counted at the edge that takes them, while the strobe stands
   always @(posedge clk) begin
      if (rx_pop === 1'b1)
         pops++;
   end
   initial forever begin
      #7 lclk = 1'b1;
      #8 lclk = 1'b0;
   end

   iac_ctrl #(.TOP_RATE(TOP), .SPK_SS_FS(SPK_SS), .SPK_HS(SPK_H), .CREDIT_W(8)) iac_ctrl_inst (
      .ref_clk_i(clk), .sys_rst_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .cmd_o(cmd), .cmd_vld_o(cvld), .cmd_rdy_i(rdy),
      .rx_data_i(rx_data), .rx_first_i(rx_first), .rx_full_i(rx_full), .rx_byte_i(rx_byte),
      .rx_pop_o(rx_pop), .ack_more_o(ack_more), .hold_bus_o(hold), .tx_empty_ctrl_o(txe),
      .master_en_o(men), .slave_en_o(sen), .speed_o(speed), .spike_len_o(spike),
      .loopback_o(loopb), .link_clk_i(lclk), .link_addr_vld_i(avld), .link_addr_i(laddr),
      .link_stop_i(lstop), .slave_match_o(smatch));
   iac_eng_model eng (.ref_clk_i(clk), .sys_rst_i(rst), .link_clk_i(lclk), .cmd_o(cmd),
      .cmd_vld_o(cvld), .cmd_rdy_i(rdy), .link_addr_vld_i(avld), .link_addr_i(laddr),
      .link_stop_i(lstop));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] xs();
      st = st ^ (st << 13);
      st = st ^ (st >> 17);
      st = st ^ (st << 5);
      return st;
   endfunction
   task automatic chk(input logic [31:0] gt, input logic [31:0] ex);
      cmp_count++;
      if (gt !== ex) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, gt, ex);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel   <= 1'b1;
      pwr    <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      // ready, read data and error are taken at the edge that ends the access
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 64);
      if (n == 64)
         failures++;
      rd  = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen  <= 1'b0;
   endtask
   // register writes also update the model; locked writes leave it alone
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] s;
      bus(1'b1, a, d);
      s = d[2:1];
      if (s == 2'h0 || s > TOP)
         s = TOP;
      if (a == OFS_EN)
         m_en = d[0];
      else if (!m_en && a == OFS_CTRL)
         m_ctl = {22'h0, d[9:3], s, d[0]};
      else if (!m_en && a == OFS_TAR)
         m_tar = {20'h0, d[11:0]};
      else if (!m_en && a == OFS_SAR)
         m_sar = {22'h0, d[9:0]};
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      cyc(16);
      rst <= 1'b0;
      cyc(4);
      rchk(OFS_CTRL, m_ctl);
      rchk(OFS_TAR, m_tar);
      rchk(OFS_SAR, m_sar);
      rchk(8'h0C, 32'h0);
      chk(err, 1'b1);
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         v = xs();
         v[6] = v[6] | v[0];
         v[2:1] = 2'(i);
         rx_full <= v[20];
         wr(OFS_CTRL, v);
         cyc(2);
         rchk(OFS_CTRL, m_ctl);
         chk(speed, m_ctl[2:1]);
         chk(spike, (m_ctl[2:1] == SPD_HIGH) ? SPK_H : SPK_SS);
         chk(hold, m_ctl[9] & v[20]);
         chk(txe, m_ctl[8]);
      end
      $display("test modes done");
      wr(OFS_TAR, 32'hFFFFF5AA);
      wr(OFS_SAR, 32'hFFFFF5AA);
      wr(OFS_CTRL, 32'h065);
      rchk(OFS_TAR, m_tar);
      rchk(OFS_SAR, m_sar);
      wr(OFS_EN, 32'h1);
      cyc(2);
      chk(men, 1'b1);
      chk(sen, 1'b0);
      wr(OFS_CTRL, 32'h0A4);
      wr(OFS_TAR, 32'h077);
      wr(OFS_SAR, 32'h066);
      rchk(OFS_CTRL, m_ctl);
      rchk(OFS_TAR, m_tar);
      rchk(OFS_SAR, m_sar);
      wr(OFS_EN, 32'h0);
      $display("test lock done");
      for (int i = 0; i < 7; i++) begin
         wr(OFS_CTRL, ct[i]);
         wr(OFS_TAR, tg[i]);
         wr(OFS_EN, 32'h1);
         v = xs();
         v = {21'h0, dc[i], v[7:0]};
         eng.slow = i % 3;
         wr(OFS_DCMD, v);
         cyc(6);
         bus(1'b0, OFS_RAW, 32'h0);
         chk(rd[RAW_ABRT_BIT], ab[i]);
         bus(1'b0, OFS_CLR_ABRT, 32'h0);
         chk(eng.got_q.size(), 32'(!ab[i]));
         if (!ab[i] && eng.got_q.size() > 0) begin
            g = eng.got_q.pop_front();
            chk({g.read, g.stop_start, g.general_call, g.wide, g.data},
                {v[8], i == 6, tg[i][11] & ~tg[i][10], ct[i][4], v[7:0]});
         end
         wr(OFS_EN, 32'h0);
      end
      $display("test commands done");
      eng.slow = 0;
      wr(OFS_CTRL, 32'h065);
      wr(OFS_EN, 32'h1);
      chk(ack_more, 1'b0);
      wr(OFS_DCMD, 32'h100);
      cyc(4);
      chk(ack_more, 1'b1);
      v = xs();
      rx_data  <= v[7:0];
      rx_first <= 1'b1;
      rx_byte  <= 1'b1;
      @(posedge clk);
      rx_byte <= 1'b0;
      cyc(2);
      chk(ack_more, 1'b0);
      rchk(OFS_DCMD, {20'h0, 1'b1, 3'h0, v[7:0]});
      eng.got_q.delete();
      wr(OFS_EN, 32'h0);
      chk(pops, 32'd1);
      $display("test receive done");
      wr(OFS_SAR, 32'h2D5);
      wr(OFS_TAR, 32'h2D5);
      for (int i = 0; i < 6; i++) begin
         wr(OFS_CTRL, sc[i]);
         wr(OFS_EN, 32'h1);
         cyc(2);
         chk(loopb, 1'b1);
         chk(sen, 1'b1);
         eng.send_addr(sw[i], sa[i]);
         @(negedge lclk);
         chk(smatch, sp[i] & sc[i][7]);
         eng.send_stop();
         cyc(8);
         bus(1'b0, OFS_RAW, 32'h0);
         chk(rd[RAW_STOP_BIT], sp[i]);
         bus(1'b0, OFS_CLR_STOP, 32'h0);
         wr(OFS_EN, 32'h0);
      end
      $display("test slave done");
      close_out();
   end

   // a hang counts as a mismatch and ends the run the normal way
   initial begin
      #100000;
      failures++;
      close_out();
   end
endmodule // iac_ctrl_tb

// *** iac_eng_model.sv ***
// bus engine stand-in: takes commands, reports addresses and stops
// assumes the controller on ref_clk_i and a free-running link clock
`timescale 1ns/1ns
module iac_eng_model (
   input  wire logic        ref_clk_i,       // system clock
   input  wire logic        sys_rst_i,       // sync reset, high
   input  wire logic        link_clk_i,      // link clock
   input  wire iac_pkg::iac_cmd_t cmd_o,     // command from controller
   input  wire logic        cmd_vld_o,       // command valid
   output logic             cmd_rdy_i,       // command taken
   output logic             link_addr_vld_i, // address pulse
   output iac_pkg::iac_saddr_t link_addr_i,  // address seen
   output logic             link_stop_i      // stop pulse
);
   import iac_pkg::*;
   int       slow = 0;  // extra cycles before a command is taken
   int       cnt  = 0;
   iac_cmd_t got_q[$];
   initial begin
      cmd_rdy_i       = 1'b0;
      link_addr_vld_i = 1'b0;
      link_addr_i     = '0;
      link_stop_i     = 1'b0;
   end
   always @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         cmd_rdy_i <= 1'b0;
         cnt       <= 0;
      end else if (cmd_vld_o && cmd_rdy_i) begin
         got_q.push_back(cmd_o);
         cmd_rdy_i <= 1'b0;
         cnt       <= 0;
      end else if (cmd_vld_o) begin
         cmd_rdy_i <= (cnt >= slow);
         cnt       <= cnt + 1;
      end
   end
   task automatic send_addr(input logic w, input logic [9:0] a);
      @(posedge link_clk_i);
      link_addr_vld_i <= 1'b1;
      link_addr_i     <= {w, a};
      @(posedge link_clk_i);
      link_addr_vld_i <= 1'b0;
      link_addr_i     <= ~{w, a};  // inverted: no stale address
   endtask
   task automatic send_stop();
      @(posedge link_clk_i);
      link_stop_i <= 1'b1;
      @(posedge link_clk_i);
      link_stop_i <= 1'b0;
   endtask
endmodule // iac_eng_model

// *** iac_pkg.sv ***
// constants and carrier types for the two-wire addressing controller
// assumes one controller instance per register space, offsets in bytes
package iac_pkg;

   // -----------------------------------------------------------------
   // register offsets
   // -----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_TAR      = 8'h04;
   localparam logic [7:0] OFS_SAR      = 8'h08;
   localparam logic [7:0] OFS_DCMD     = 8'h10;
   localparam logic [7:0] OFS_RAW      = 8'h34;
   localparam logic [7:0] OFS_CLR_ABRT = 8'h54;
   localparam logic [7:0] OFS_CLR_STOP = 8'h60;
   localparam logic [7:0] OFS_EN       = 8'h6C;

   // -----------------------------------------------------------------
   // field positions and reset values
   // -----------------------------------------------------------------
   localparam int RAW_ABRT_BIT   = 6;
   localparam int RAW_STOP_BIT   = 9;
   localparam int DCMD_READ_BIT  = 8;
   localparam int DCMD_STOP_BIT  = 9;
   localparam int DCMD_RSTRT_BIT = 10;
   localparam int DCMD_FIRST_BIT = 11;
   localparam logic [10:0] CTRL_RST = 11'h065;
   localparam logic [11:0] TAR_RST  = 12'h055;
   localparam logic [9:0]  SAR_RST  = 10'h055;

   // speed codes
   localparam logic [1:0] SPD_STD  = 2'h1;
   localparam logic [1:0] SPD_FAST = 2'h2;
   localparam logic [1:0] SPD_HIGH = 2'h3;

   typedef struct packed {
      logic       stop_irq_master_always;
      logic       hold_bus_on_rx_full;
      logic       tx_empty_ctrl;
      logic       stop_irq_when_matched;
      logic       slave_off;
      logic       repeated_start_allow;
      logic       master_wide_addressing;
      logic       slave_wide_addressing;
      logic [1:0] speed;
      logic       master_on;
   } iac_ctrl_t;

   typedef struct packed {
      logic       special;
      logic       general_call_or_start_byte;
      logic [9:0] addr;
   } iac_tar_t;

   typedef struct packed {
      logic       read;
      logic       stop;
      logic       restart;
      logic       stop_start;
      logic       wide;
      logic       general_call;
      logic       start_byte;
      logic [9:0] addr;
      logic [7:0] data;
   } iac_cmd_t;

   typedef struct packed {
      logic       wide;
      logic [9:0] addr;
   } iac_saddr_t;

endpackage
